// File: design/sync_pg_pkg.sv
package sync_pg_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SYNC_MIN_PERIOD_NS = 20;
	localparam int SYNC_MAX_PERIOD_NS = 5000;
	localparam int MODE_SETTLE_NS = 10000;
	localparam int DEFAULT_PERIOD_NS = 500;
	localparam int PHASE_TOL_NS = 10;
	localparam int FAULT_FILTER_NS = 15000;
	localparam int RELEASE_DELAY_NS = 2000000;
	localparam int SOFTSTART_TIMEOUT_NS = 10000000;
	// least times round up, longest times round down
	localparam int SYNC_MIN_CYC = (SYNC_MIN_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SYNC_MAX_CYC = (SYNC_MAX_PERIOD_NS * 1000) / CLK_PERIOD_PS;
	localparam int MODE_SETTLE_CYC = (MODE_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DEFAULT_PERIOD_CYC = (DEFAULT_PERIOD_NS * 1000) / CLK_PERIOD_PS;
	localparam int PHASE_TOL_CYC = (PHASE_TOL_NS * 1000) / CLK_PERIOD_PS;
	localparam int FAULT_FILTER_CYC = (FAULT_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RELEASE_DELAY_CYC = (RELEASE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SOFTSTART_TIMEOUT_CYC = SOFTSTART_TIMEOUT_NS / CLK_PERIOD_PS * 1000;

	// ==========================================================
	// pulse counts
	localparam int SYNC_ENTRY_PULSES = 2048;
	localparam int PULSE_CTRL_PULSES = 4;
	localparam int DOUBLE_PULSES = 2;

	// ==========================================================
	// register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam int CTRL_SYNC_ALLOW_BIT = 0;
	localparam logic CTRL_SYNC_ALLOW_RST = 1'b1;

	// ==========================================================
	// asynchronous input bit positions
	localparam int AIN_W = 10;
	localparam int AIN_PIN = 0;
	localparam int AIN_BELOW_UV = 1;
	localparam int AIN_ABOVE_OV = 2;
	localparam int AIN_ABOVE_UV_HYST = 3;
	localparam int AIN_BELOW_OV_HYST = 4;
	localparam int AIN_THERM_HOT = 5;
	localparam int AIN_THERM_COOL = 6;
	localparam int AIN_EN_ON = 7;
	localparam int AIN_VCC_OK = 8;
	localparam int AIN_VCC_LOW = 9;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		SY_FREE = 2'b00,
		SY_COUNT = 2'b01,
		SY_LOCKED = 2'b11
	} sync_state_e;

	typedef struct packed {
		logic forced_pulse_width_mode;
		logic sync_mode;
		logic spread_en;
		logic pulse_ctrl;
		logic freq_locked;
		logic phase_locked;
	} mode_status_s;

	typedef struct packed {
		logic uv;
		logic ov;
		logic thermal;
		logic enable;
		logic vcc;
		logic softstart;
	} fault_set_s;

endpackage : sync_pg_pkg

// File: design/sync_mode_and_power_good_logic.sv
// How it works
// - sync entry after 2048 continuous valid pulses
// - steady pin: leave sync, pick mode, spread on unless a double pulse came before
// - valid sync starts lock, switches near pulse 2048
// - one bridging period between default and sync
// - then step phase until edges align
// - first sync edge enables spread spectrum
// - spread spectrum off at frequency switch-over
// - reduced-frequency condition postpones the lock
// - power flag low when outside window
// - short excursions never trip the flag
// - flag pin only pulls low
// - enable low forces flag low
// - release delay after every fault ends
// - uv/ov trip filtered, clear needs hysteresis
// - other faults clear at threshold plus regulation
// - flag low during soft start or timeout
// - flag stays valid low while enable low
// - no switching while internal supply locked out
// - fourth valid pulse makes pulse control permanent
// - pulse control: high forced_pulse_width_mode, low auto, clock sync
// - valid double pulse turns spread off
// - sync mode acts as forced pwm
`timescale 1ns/100ps
module sync_mode_and_power_good_logic
	import sync_pg_pkg::*;
#(
	parameter int PERIOD_W = 12,
	parameter int DEFAULT_PERIOD = DEFAULT_PERIOD_CYC,
	parameter int LONG_W = 22,
	parameter int RELEASE_CYC = RELEASE_DELAY_CYC,
	parameter int SS_CYC = SOFTSTART_TIMEOUT_CYC
) (
	// clock, restart and freeze
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clk_en,
	// mode/sync pin and comparators, all asynchronous
	input wire logic mode_sync_pin,
	input wire logic fb_below_uv,
	input wire logic fb_above_ov,
	input wire logic fb_above_uv_hyst,
	input wire logic fb_below_ov_hyst,
	input wire logic thermal_trip_rising,
	input wire logic thermal_trip_falling,
	input wire logic en_above_rising,
	input wire logic vcc_above_lockout,
	input wire logic vcc_below_lockout_hyst,
	// converter core, same clock
	input wire logic freq_reduced,
	input wire logic softstart_done,
	input wire logic switch_node_rise,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// mode and clock control to the core
	output mode_status_s mode,
	output logic diode_emul_off,
	output logic [PERIOD_W-1:0] clk_period,
	output logic phase_step,
	output logic switching_inhibit,
	// open-drain power flag
	output logic power_ok_flag_o,
	output logic power_ok_flag_oe
);

	// ==========================================================
	// parameter checks
	generate
		if (PERIOD_W < 12 || DEFAULT_PERIOD < 1 || DEFAULT_PERIOD >= (1 << PERIOD_W)
				|| RELEASE_CYC < 1 || RELEASE_CYC >= (1 << LONG_W)
				|| SS_CYC < 1 || SS_CYC >= (1 << LONG_W)) begin : g_bad_param
			$error("parameter values out of range");
		end
	endgenerate

	localparam logic [11:0] C_MIN = 12'(SYNC_MIN_CYC);
	localparam logic [11:0] C_MAX = 12'(SYNC_MAX_CYC);
	localparam logic [11:0] C_SETTLE = 12'(MODE_SETTLE_CYC);
	localparam logic [11:0] C_ENTRY = 12'(SYNC_ENTRY_PULSES);
	localparam logic [11:0] C_PCTRL = 12'(PULSE_CTRL_PULSES);
	localparam logic [11:0] C_DOUBLE = 12'(DOUBLE_PULSES);
	localparam logic [11:0] C_PTOL = 12'(PHASE_TOL_CYC);
	localparam logic [11:0] C_FILT = 12'(FAULT_FILTER_CYC);
	localparam logic [LONG_W-1:0] C_REL = LONG_W'(RELEASE_CYC);
	localparam logic [LONG_W-1:0] C_SS = LONG_W'(SS_CYC);
	localparam logic [PERIOD_W-1:0] C_DEF = PERIOD_W'(DEFAULT_PERIOD);

	// ==========================================================
	// input synchronisers
	logic [AIN_W-1:0] ain;
	logic [AIN_W-1:0] ain_meta;
	logic [AIN_W-1:0] ain_q;
	logic pin_d;

	assign ain = {vcc_below_lockout_hyst, vcc_above_lockout, en_above_rising,
		thermal_trip_falling, thermal_trip_rising, fb_below_ov_hyst,
		fb_above_uv_hyst, fb_above_ov, fb_below_uv, mode_sync_pin};

	// the meta stage feeds only the second stage
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ain_meta <= '0;
			ain_q <= '0;
			pin_d <= 1'b0;
		end else if (clk_en) begin
			ain_meta <= ain;
			ain_q <= ain_meta;
			pin_d <= ain_q[AIN_PIN];
		end
	end

	// ==========================================================
	// pin edge and timing measurement
	wire pin_q = ain_q[AIN_PIN];
	wire pin_rise = pin_q & ~pin_d;
	wire pin_edge = pin_q ^ pin_d;
	logic [11:0] since_rise;
	logic [11:0] steady_cnt;
	logic [11:0] train_cnt;
	logic [11:0] sw_age;
	wire period_ok = (since_rise >= C_MIN) && (since_rise <= C_MAX);
	wire steady_hit = (steady_cnt == C_SETTLE - 12'h001) && !pin_edge;
	wire [11:0] next_train = !pin_rise ? train_cnt :
		!period_ok ? 12'h001 :
		(train_cnt == C_ENTRY) ? train_cnt : train_cnt + 12'h001;

	// counters saturate so a dead pin never wraps into a valid period
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			since_rise <= 12'hFFF;
			steady_cnt <= 12'h000;
			train_cnt <= 12'h000;
			sw_age <= 12'hFFF;
		end else if (clk_en) begin
			since_rise <= pin_rise ? 12'h001 :
				(since_rise == 12'hFFF) ? since_rise : since_rise + 12'h001;
			steady_cnt <= pin_edge ? 12'h000 :
				(steady_cnt == C_SETTLE) ? steady_cnt : steady_cnt + 12'h001;
			train_cnt <= steady_hit ? 12'h000 : next_train;
			sw_age <= switch_node_rise ? 12'h000 :
				(sw_age == 12'hFFF) ? sw_age : sw_age + 12'h001;
		end
	end

	// ==========================================================
	// control register and lock decisions
	logic sync_allow;
	logic bridge_pend;
	sync_state_e state;
	sync_state_e next_state;
	wire lock_go = (state == SY_COUNT) && (train_cnt == C_ENTRY) && sync_allow
		&& !freq_reduced;
	wire [PERIOD_W:0] bridge_sum = {1'b0, C_DEF} + {1'b0, PERIOD_W'(since_rise)};
	wire [PERIOD_W-1:0] bridge_len = bridge_sum[PERIOD_W:1];
	wire phase_close = (sw_age <= C_PTOL);

	// train state: counting pulses, then locked on the external clock
	always_comb begin
		next_state = state;
		case (state)
			SY_FREE: if (pin_rise && period_ok) next_state = SY_COUNT;
			SY_COUNT: begin
				if (steady_hit || (pin_rise && !period_ok)) next_state = SY_FREE;
				else if (lock_go && pin_rise) next_state = SY_LOCKED;
			end
			SY_LOCKED: if (steady_hit || (pin_rise && !period_ok)) next_state = SY_FREE;
			default: next_state = SY_FREE;
		endcase
	end

	// lock only on a sync rising edge, so the bridging period starts in phase
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state <= SY_FREE;
			sync_allow <= CTRL_SYNC_ALLOW_RST;
		end else if (clk_en) begin
			state <= next_state;
			if (reg_wr && reg_addr == REG_CTRL) sync_allow <= reg_wdata[CTRL_SYNC_ALLOW_BIT];
		end
	end

	// ==========================================================
	// mode and spread selection
	wire enter_sync = (state == SY_COUNT) && (next_state == SY_LOCKED);
	wire leave_sync = (state == SY_LOCKED) && (next_state == SY_FREE);
	wire double_seen = mode.pulse_ctrl && (train_cnt == C_DOUBLE);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mode <= '{default: 1'b0, spread_en: 1'b1};
			diode_emul_off <= 1'b0;
		end else if (clk_en) begin
			if (pin_rise && period_ok && next_train == C_PCTRL)
				mode.pulse_ctrl <= 1'b1;
			if (enter_sync) begin
				mode.sync_mode <= 1'b1;
				mode.spread_en <= 1'b0;
			end else if (steady_hit) begin
				mode.sync_mode <= 1'b0;
				mode.forced_pulse_width_mode <= pin_q;
				mode.spread_en <= !double_seen;
			end else if (leave_sync) begin
				// a broken train drops sync at once, so spread never runs beside sync
				mode.sync_mode <= 1'b0;
				mode.spread_en <= 1'b1;
			end else if (pin_rise && state == SY_FREE && mode.pulse_ctrl) begin
				mode.spread_en <= 1'b1;
			end
			if (enter_sync || leave_sync) mode.freq_locked <= 1'b0;
			else if (bridge_pend && pin_rise) mode.freq_locked <= 1'b1;
			if (leave_sync || enter_sync) mode.phase_locked <= 1'b0;
			else if (mode.freq_locked && pin_rise && phase_close)
				mode.phase_locked <= 1'b1;
			diode_emul_off <= mode.forced_pulse_width_mode || mode.sync_mode;
		end
	end

	// ==========================================================
	// switching period and phase trim
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			clk_period <= C_DEF;
			bridge_pend <= 1'b0;
			phase_step <= 1'b0;
		end else if (clk_en) begin
			phase_step <= 1'b0;
			if (enter_sync) begin
				clk_period <= bridge_len;
				bridge_pend <= 1'b1;
			end else if (leave_sync) begin
				clk_period <= C_DEF;
				bridge_pend <= 1'b0;
			end else if (bridge_pend && pin_rise) begin
				clk_period <= PERIOD_W'(since_rise);
				bridge_pend <= 1'b0;
			end else if (mode.freq_locked && pin_rise && !phase_close) begin
				phase_step <= 1'b1;
			end
		end
	end

	// ==========================================================
	// power-good fault qualification
	wire uv_q = ain_q[AIN_BELOW_UV];
	wire ov_q = ain_q[AIN_ABOVE_OV];
	wire en_q = ain_q[AIN_EN_ON];
	wire in_reg = ain_q[AIN_ABOVE_UV_HYST] & ain_q[AIN_BELOW_OV_HYST];
	logic [11:0] uv_cnt;
	logic [11:0] ov_cnt;
	logic [LONG_W-1:0] ss_cnt;
	logic [LONG_W-1:0] rel_cnt;
	logic power_good;
	fault_set_s flt;
	fault_set_s next_flt;
	wire uv_trip = uv_q && (uv_cnt == C_FILT - 12'h001);
	wire ov_trip = ov_q && (ov_cnt == C_FILT - 12'h001);
	wire any_fault = (|flt) || !en_q;
	wire next_pg = !any_fault && (rel_cnt == C_REL);

	// a new trip wins over a clear that lands in the same cycle
	always_comb begin
		next_flt.uv = uv_trip || (flt.uv && !in_reg);
		next_flt.ov = ov_trip || (flt.ov && !in_reg);
		next_flt.thermal = ain_q[AIN_THERM_HOT] ||
			(flt.thermal && !(ain_q[AIN_THERM_COOL] && in_reg));
		next_flt.enable = !en_q || (flt.enable && !in_reg);
		next_flt.vcc = ain_q[AIN_VCC_LOW] ||
			(flt.vcc && !(ain_q[AIN_VCC_OK] && in_reg));
		next_flt.softstart = flt.softstart && !softstart_done && (ss_cnt != C_SS);
	end

	// soft start is pending from every restart
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			flt <= '{default: 1'b0, softstart: 1'b1};
			uv_cnt <= 12'h000;
			ov_cnt <= 12'h000;
			ss_cnt <= '0;
		end else if (clk_en) begin
			flt <= next_flt;
			uv_cnt <= (uv_q && !uv_trip) ? uv_cnt + 12'h001 : 12'h000;
			ov_cnt <= (ov_q && !ov_trip) ? ov_cnt + 12'h001 : 12'h000;
			ss_cnt <= flt.softstart ? ss_cnt + 1'b1 : ss_cnt;
		end
	end

	// ==========================================================
	// release delay and pin drive
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rel_cnt <= '0;
			power_good <= 1'b0;
			power_ok_flag_o <= 1'b0;
			power_ok_flag_oe <= 1'b1;
			switching_inhibit <= 1'b1;
		end else if (clk_en) begin
			rel_cnt <= any_fault ? '0 : (rel_cnt == C_REL) ? rel_cnt : rel_cnt + 1'b1;
			power_good <= next_pg;
			power_ok_flag_o <= 1'b0;
			power_ok_flag_oe <= !next_pg;
			switching_inhibit <= !ain_q[AIN_VCC_OK];
		end
	end

	// ==========================================================
	// register read port, data one cycle after the strobe
	wire [31:0] status_word = {20'h00000, flt, mode};
	wire [31:0] rd_mux = (reg_addr == REG_CTRL) ? {31'h00000000, sync_allow} :
		(reg_addr == REG_STATUS) ? status_word : 32'h00000000;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) reg_rdata <= 32'h00000000;
		else if (clk_en) reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	sequence s_enter;
		clk_en && (state == SY_COUNT) ##1 (state == SY_LOCKED);
	endsequence

	sequence s_bridge;
		$rose(bridge_pend) ##0 mode.sync_mode;
	endsequence

	a_pulse_ctrl_sticky: assert property (mode.pulse_ctrl |=> mode.pulse_ctrl)
		else $error("pulse control dropped");
	a_sync_no_spread: assert property (mode.sync_mode |-> !mode.spread_en)
		else $error("spread on in sync mode");
	a_sync_as_forced_pulse_width_mode: assert property (clk_en && mode.sync_mode |=> diode_emul_off)
		else $error("diode emulation on in sync");
	a_lock_entry: assert property (s_enter |-> $past(train_cnt) == C_ENTRY
		&& !$past(freq_reduced))
		else $error("lock without full train");
	a_bridge_len: assert property (s_bridge |-> clk_period >= $past(since_rise)
		&& clk_period <= C_DEF || clk_period <= $past(since_rise)
		&& clk_period >= C_DEF)
		else $error("bridge period out of range");
	a_en_low_flag: assert property (clk_en && !en_q |=> power_ok_flag_oe)
		else $error("flag not low with enable low");
	a_ss_holds_low: assert property (clk_en && flt.softstart |=> power_ok_flag_oe)
		else $error("flag released in soft start");
	a_uv_filtered: assert property ($rose(flt.uv) |-> $past(uv_cnt) == C_FILT - 12'h001)
		else $error("uv fault without full filter");
	a_release_wait: assert property ($rose(power_good) |-> rel_cnt == C_REL)
		else $error("flag released early");
	a_vcc_inhibit: assert property (clk_en && !ain_q[AIN_VCC_OK] |=> switching_inhibit)
		else $error("switching with supply locked out");

endmodule : sync_mode_and_power_good_logic

// File: testbench/mode_sync_driver.sv
`timescale 1ns/100ps
// ==========================================================
// controller that drives the mode/sync pin
module mode_sync_driver (
	// pin towards the converter
	output logic pin
);
	// pin idles low until the first command
	initial begin
		pin = 1'b0;
	end

	// n rising edges with a 48 ns period, ending low
	task burst(input int n);
		for (int i = 0; i < n; i++) begin
			pin = 1'b1;
			#24;
			pin = 1'b0;
			#24;
		end
	endtask : burst

	// steady level for a given time
	task hold(input logic v, input int ns);
		pin = v;
		#(ns);
	endtask : hold
endmodule : mode_sync_driver

// File: testbench/sync_mode_and_power_good_logic_tb.sv
`timescale 1ns/100ps
module sync_mode_and_power_good_logic_tb;
	import sync_pg_pkg::*;
	// ==========================================================
	// stimulus and observation
	logic mclk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, mode_sync_pin;
	logic fb_below_uv = 1'b0, fb_above_ov = 1'b0, fb_above_uv_hyst = 1'b1;
	logic fb_below_ov_hyst = 1'b1, thermal_trip_rising = 1'b0, thermal_trip_falling = 1'b1;
	logic en_above_rising = 1'b1, vcc_above_lockout = 1'b1, vcc_below_lockout_hyst = 1'b0;
	logic freq_reduced = 1'b0, softstart_done = 1'b1, switch_node_rise = 1'b0;
	logic sn_follow = 1'b0, pin_last = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
	logic reg_wr = 1'b0, reg_rd = 1'b0, diode_emul_off, phase_step, switching_inhibit;
	logic power_ok_flag_o, power_ok_flag_oe;
	logic [11:0] clk_period;
	mode_status_s mode;
	int mismatches = 0, tests_run = 0, phase_steps = 0;

	always #2.5 mclk = ~mclk;

	// core model: once following, a switch-node rise comes one cycle after each pin rise
	always @(posedge mclk) begin
		pin_last <= mode_sync_pin;
		switch_node_rise <= sn_follow && mode_sync_pin && !pin_last;
		if (phase_step === 1'b1) phase_steps <= phase_steps + 1;
	end

	mode_sync_driver u_mode_sync_driver (.pin(mode_sync_pin));

	// short release and soft-start counts keep the run brief
	sync_mode_and_power_good_logic #(.RELEASE_CYC(20), .SS_CYC(50)) u_sync_mode_and_power_good_logic (
		.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .mode_sync_pin(mode_sync_pin),
		.fb_below_uv(fb_below_uv), .fb_above_ov(fb_above_ov), .fb_above_uv_hyst(fb_above_uv_hyst),
		.fb_below_ov_hyst(fb_below_ov_hyst), .thermal_trip_rising(thermal_trip_rising),
		.thermal_trip_falling(thermal_trip_falling), .en_above_rising(en_above_rising),
		.vcc_above_lockout(vcc_above_lockout), .vcc_below_lockout_hyst(vcc_below_lockout_hyst),
		.freq_reduced(freq_reduced), .softstart_done(softstart_done),
		.switch_node_rise(switch_node_rise), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode(mode),
		.diode_emul_off(diode_emul_off), .clk_period(clk_period), .phase_step(phase_step),
		.switching_inhibit(switching_inhibit), .power_ok_flag_o(power_ok_flag_o),
		.power_ok_flag_oe(power_ok_flag_oe));

	// ==========================================================
	// verdict and comparison
	task complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run

	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// ==========================================================
	// bus cycles and bounded waits
	task reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : reg_write

	// read data stands only in the cycle after the strobe
	task reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_read

	// sel: 0 flag pull-down, 1 pulse control, 2 sync mode, 3 spread, 4 forced pwm
	task wait_bit(input int sel, input logic v, input int bound);
		logic s;
		for (int i = 0; i < bound; i++) begin
			@(posedge mclk);
			#1;
			case (sel)
				0: s = power_ok_flag_oe;
				1: s = mode.pulse_ctrl;
				2: s = mode.sync_mode;
				3: s = mode.spread_en;
				default: s = mode.forced_pulse_width_mode;
			endcase
			if (s === v) return;
		end
		mismatches++;
		$display("CHECK FAILED at %0t: wait on signal %0d timed out", $time, sel);
		complete_run();
	endtask : wait_bit

	task cycles(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cycles

	// ==========================================================
	// main sequence
	initial begin
		cycles(5);
		rst_b <= 1'b1;
		#1;
		// reset state and register map
		check({26'h0, mode}, 32'h8);
		check({31'h0, power_ok_flag_oe}, 32'h1);
		check({31'h0, power_ok_flag_o}, 32'h0);
		check({20'h0, clk_period}, 32'h64);
		reg_read(REG_CTRL, rd);
		check(rd, 32'h1);
		reg_write(REG_CTRL, 32'h0);
		reg_read(REG_CTRL, rd);
		check(rd, 32'h0);
		reg_write(REG_CTRL, 32'h1);
		reg_write(8'h08, 32'hFFFF_FFFF);
		reg_read(8'h08, rd);
		check(rd, 32'h0);
		$display("test registers done");
		// release waits the full delay after the last fault ends
		cycles(8);
		check({31'h0, power_ok_flag_oe}, 32'h1);
		wait_bit(0, 1'b0, 60);
		// short undervoltage excursion is filtered out
		fb_below_uv <= 1'b1;
		fb_above_uv_hyst <= 1'b0;
		cycles(2000);
		check({31'h0, power_ok_flag_oe}, 32'h0);
		fb_below_uv <= 1'b0;
		fb_above_uv_hyst <= 1'b1;
		cycles(20);
		// long excursion trips, clearing needs the hysteresis window
		fb_below_uv <= 1'b1;
		fb_above_uv_hyst <= 1'b0;
		cycles(2990);
		check({31'h0, power_ok_flag_oe}, 32'h0);
		wait_bit(0, 1'b1, 20);
		reg_read(REG_STATUS, rd);
		check({31'h0, rd[11]}, 32'h1);
		fb_below_uv <= 1'b0;
		cycles(60);
		check({31'h0, power_ok_flag_oe}, 32'h1);
		fb_above_uv_hyst <= 1'b1;
		cycles(15);
		check({31'h0, power_ok_flag_oe}, 32'h1);
		wait_bit(0, 1'b0, 40);
		// overvoltage trips after the filter, clearing needs the inner window
		fb_above_ov <= 1'b1;
		fb_below_ov_hyst <= 1'b0;
		wait_bit(0, 1'b1, 3020);
		reg_read(REG_STATUS, rd);
		check({31'h0, rd[10]}, 32'h1);
		fb_above_ov <= 1'b0;
		cycles(20);
		check({31'h0, power_ok_flag_oe}, 32'h1);
		fb_below_ov_hyst <= 1'b1;
		wait_bit(0, 1'b0, 40);
		// enable low pulls the flag at once, but only while the clock enable runs
		@(posedge mclk);
		clk_en <= 1'b0;
		en_above_rising <= 1'b0;
		cycles(10);
		check({31'h0, power_ok_flag_oe}, 32'h0);
		@(posedge mclk);
		clk_en <= 1'b1;
		wait_bit(0, 1'b1, 6);
		cycles(40);
		check({31'h0, power_ok_flag_oe}, 32'h1);
		en_above_rising <= 1'b1;
		wait_bit(0, 1'b0, 40);
		// thermal fault clears only at its own release level
		thermal_trip_rising <= 1'b1;
		thermal_trip_falling <= 1'b0;
		wait_bit(0, 1'b1, 6);
		thermal_trip_rising <= 1'b0;
		cycles(40);
		check({31'h0, power_ok_flag_oe}, 32'h1);
		thermal_trip_falling <= 1'b1;
		wait_bit(0, 1'b0, 40);
		// internal supply lockout stops switching
		vcc_above_lockout <= 1'b0;
		vcc_below_lockout_hyst <= 1'b1;
		cycles(6);
		check({31'h0, switching_inhibit}, 32'h1);
		vcc_above_lockout <= 1'b1;
		vcc_below_lockout_hyst <= 1'b0;
		cycles(6);
		check({31'h0, switching_inhibit}, 32'h0);
		wait_bit(0, 1'b0, 40);
		$display("test power flag done");
		// four valid pulses switch to pulse control, steady high picks forced pwm
		u_mode_sync_driver.burst(3);
		check({31'h0, mode.pulse_ctrl}, 32'h0);
		u_mode_sync_driver.burst(1);
		wait_bit(1, 1'b1, 6);
		u_mode_sync_driver.hold(1'b1, 100);
		wait_bit(4, 1'b1, 2200);
		check({31'h0, mode.spread_en}, 32'h1);
		cycles(1);
		check({31'h0, diode_emul_off}, 32'h1);
		// steady low picks auto, then a double pulse drops spread
		u_mode_sync_driver.hold(1'b0, 100);
		wait_bit(4, 1'b0, 2200);
		check({31'h0, mode.spread_en}, 32'h1);
		u_mode_sync_driver.burst(2);
		cycles(2100);
		check({26'h0, mode}, 32'h4);
		// sync train: spread on at first edge, sync only after the full count
		u_mode_sync_driver.burst(1);
		cycles(1);
		check({31'h0, mode.spread_en}, 32'h1);
		u_mode_sync_driver.burst(2000);
		check({31'h0, mode.sync_mode}, 32'h0);
		// a folded-back core clock holds the lock off although the count is full
		@(posedge mclk);
		freq_reduced <= 1'b1;
		u_mode_sync_driver.burst(60);
		check({31'h0, mode.sync_mode}, 32'h0);
		@(posedge mclk);
		freq_reduced <= 1'b0;
		u_mode_sync_driver.burst(30);
		check({31'h0, mode.sync_mode}, 32'h1);
		check({31'h0, mode.spread_en}, 32'h0);
		check({31'h0, mode.freq_locked}, 32'h1);
		check({31'h0, diode_emul_off}, 32'h1);
		check({31'h0, (clk_period >= 12'h009 && clk_period <= 12'h00A)}, 32'h1);
		// unaligned edges ask for trim steps; once the core follows, phase locks
		sn_follow = 1'b1;
		u_mode_sync_driver.burst(30);
		check({31'h0, mode.phase_locked}, 32'h1);
		check({31'h0, (phase_steps != 0)}, 32'h1);
		// steady pin leaves sync for auto with spread on
		u_mode_sync_driver.hold(1'b0, 100);
		wait_bit(2, 1'b0, 2200);
		check({26'h0, mode}, 32'hC);
		$display("test mode pin done");
		// restart brings back level-driven control
		@(posedge mclk);
		rst_b <= 1'b0;
		softstart_done <= 1'b0;
		cycles(3);
		check({31'h0, mode.pulse_ctrl}, 32'h0);
		check({26'h0, mode}, 32'h8);
		check({31'h0, power_ok_flag_oe}, 32'h1);
		rst_b <= 1'b1;
		u_mode_sync_driver.burst(3);
		check({31'h0, mode.pulse_ctrl}, 32'h0);
		// without full output the soft-start hold ends on its timeout
		cycles(10);
		check({31'h0, power_ok_flag_oe}, 32'h1);
		wait_bit(0, 1'b0, 60);
		$display("test restart done");
		complete_run();
	end
endmodule : sync_mode_and_power_good_logic_tb
